//--- hw/pbc_bus_ctl.sv
// bus control signalling for master and slave roles
// Behaviour
// - master frame asserted until final data phase
// - data phase completes when both readies asserted
// - initiator ready only with valid data or room, or while ending on stop or abort
// - target ready only with valid data or room
// - master drives initiator ready, slave target ready
// - slave requests stop; master ends on stop
// - configuration access claimed only with select input
// - slave claims decoded access; master watches claim
// - address parity error pulls system error one clock
// - data parity error flagged two clocks after data
// - parity error held one clock per bad phase
// - no data parity report for special cycles
// - interrupt line low while condition persists
// - own request line, grant returned separately
// - bus signals sampled on rising clock edge
// - reset floats all outputs, sequencers reset
// - drive line high one clock before floating
// - even parity over data and command lines
// - address phase is first framed clock
module pbc_bus_ctl
(
   input  wire logic        clk,
   input  wire logic        rst_b,
   input  wire logic        frame_b_i,
   output logic             frame_b_o,
   output logic             frame_b_oe_b,
   input  wire logic        irdy_b_i,
   output logic             irdy_b_o,
   output logic             irdy_b_oe_b,
   input  wire logic        trdy_b_i,
   output logic             trdy_b_o,
   output logic             trdy_b_oe_b,
   input  wire logic        stop_b_i,
   output logic             stop_b_o,
   output logic             stop_b_oe_b,
   input  wire logic        devsel_b_i,
   output logic             devsel_b_o,
   output logic             devsel_b_oe_b,
   input  wire logic        idsel_i,
   output logic             perr_b_o,
   output logic             perr_b_oe_b,
   output logic             serr_b_o,
   output logic             serr_b_oe_b,
   output logic             inta_b_o,
   output logic             inta_b_oe_b,
   output logic             req_b_o,
   output logic             req_b_oe_b,
   input  wire logic        gnt_b_i,
   input  wire logic [31:0] ad_i,
   output logic [31:0]      ad_o,
   output logic             ad_oe_b,
   input  wire logic [3:0]  cbe_b_i,
   output logic [3:0]       cbe_b_o,
   output logic             cbe_b_oe_b,
   input  wire logic        par_i,
   output logic             par_o,
   output logic             par_oe_b,
   input  wire logic        mst_req,
   input  wire logic [3:0]  mst_cmd,
   input  wire logic [31:0] mst_addr,
   input  wire logic [3:0]  mst_be,
   input  wire logic [31:0] mst_wdata,
   input  wire logic        mst_rdy,
   input  wire logic        mst_last,
   output logic             mst_ack,
   output logic [31:0]      mst_rdata,
   output logic             mst_end,
   output logic             mst_stopped,
   output logic             mst_aborted,
   input  wire logic [31:0] slv_base,
   input  wire logic [31:0] slv_mask,
   input  wire logic        slv_rdy,
   input  wire logic        slv_stop,
   input  wire logic [31:0] slv_rdata,
   output logic             slv_sel,
   output logic [3:0]       slv_cmd,
   output logic [31:0]      slv_addr,
   output logic             slv_ack,
   output logic [31:0]      slv_wdata,
   output logic             slv_end,
   input  wire logic        irq
);
   pbc_pkg::pbc_mst_st_t m_st_ff, nxt_m_st;
   pbc_pkg::pbc_slv_st_t s_st_ff, nxt_s_st;
   logic        m_frame_act, m_irdy_act, m_own, m_done, m_stop, m_abort;
   logic        s_devsel_act, s_trdy_act, s_stop_act, s_own, s_done, s_fin;
   logic        s_addr_ph, s_hit, s_cfg, s_mem;
   logic        frame_s, irdy_s, trdy_s, stop_s, devsel_s, gnt_s;
   logic        frame_on, irdy_on, trdy_on, stop_on;
   logic        frame_q_ff, m_claim_ff, m_wr_ff, s_wr_ff, aq_ff, dq_ff;
   logic [2:0]  m_wait_ff;
   logic [3:0]  m_cmd_ff;
   logic [35:0] chk_ff;
   logic        chk_par, chk_bad, gen_par, rx_data;
   logic [31:0] ad_o_ff, nxt_ad;
   logic [3:0]  cbe_b_o_ff, nxt_cbe;
   logic        ad_oe_b_ff, nxt_ad_oe_b, cbe_b_oe_b_ff, nxt_cbe_oe_b;
   logic        par_o_ff, par_oe_b_ff, serr_b_o_ff, serr_b_oe_b_ff;
   logic        inta_b_o_ff, inta_b_oe_b_ff, req_b_o_ff, req_b_oe_b_ff;
   logic        mst_ack_ff, mst_end_ff, mst_stopped_ff, mst_aborted_ff;
   logic        slv_sel_ff, slv_ack_ff, slv_end_ff;
   logic [31:0] mst_rdata_ff, slv_addr_ff, slv_wdata_ff;
   logic [3:0]  slv_cmd_ff;

   // asserted views of bus inputs, taken on the rising edge
   assign frame_s  = !frame_b_i;
   assign irdy_s   = !irdy_b_i;
   assign trdy_s   = !trdy_b_i;
   assign stop_s   = !stop_b_i;
   assign devsel_s = !devsel_b_i;
   assign gnt_s    = !gnt_b_i;
   assign frame_on = !frame_b_o;
   assign irdy_on  = !irdy_b_o;
   assign trdy_on  = !trdy_b_o;
   assign stop_on  = !stop_b_o;

   // master sequencer
   always_comb
   begin
      nxt_m_st    = m_st_ff;
      m_frame_act = 1'b0;
      m_irdy_act  = 1'b0;
      m_own       = 1'b0;
      m_done      = (m_st_ff == pbc_pkg::M_DATA) && irdy_on && trdy_s;
      m_stop      = (m_st_ff == pbc_pkg::M_DATA) && stop_s;
      m_abort     = (m_st_ff == pbc_pkg::M_DATA) && !m_claim_ff
                    && (m_wait_ff == pbc_pkg::DEVSEL_WAIT);
      case (m_st_ff)
         pbc_pkg::M_IDLE:
            if (mst_req && gnt_s && !frame_s && !irdy_s && s_st_ff == pbc_pkg::S_IDLE)
            begin
               nxt_m_st    = pbc_pkg::M_ADDR;
               m_frame_act = 1'b1;
               m_own       = 1'b1;
            end
         pbc_pkg::M_ADDR:
         begin
            nxt_m_st    = pbc_pkg::M_DATA;
            m_own       = 1'b1;
            m_irdy_act  = mst_rdy;
            m_frame_act = !(mst_last && mst_rdy);
         end
         pbc_pkg::M_DATA:
         begin
            m_own = 1'b1;
            if (!frame_on && (m_done || m_stop || m_abort))
            begin
               nxt_m_st = pbc_pkg::M_TURN;
               m_own    = 1'b0;
            end
            else if (m_stop || m_abort)
               m_irdy_act = 1'b1;
            else
            begin
               m_irdy_act  = !m_done && (irdy_on || mst_rdy);
               m_frame_act = frame_on && !(mst_last && m_irdy_act);
            end
         end
         default:
            nxt_m_st = pbc_pkg::M_IDLE;
      endcase
   end

   // slave decode and sequencer
   assign s_addr_ph = frame_s && !frame_q_ff && (m_st_ff != pbc_pkg::M_ADDR);
   assign s_cfg     = idsel_i && (cbe_b_i == pbc_pkg::CMD_CFG_RD
                      || cbe_b_i == pbc_pkg::CMD_CFG_WR);
   assign s_mem     = (cbe_b_i == pbc_pkg::CMD_MEM_RD || cbe_b_i == pbc_pkg::CMD_MEM_WR)
                      && ((ad_i & slv_mask) == slv_base);
   assign s_hit     = s_addr_ph && (s_cfg || s_mem);

   always_comb
   begin
      nxt_s_st     = s_st_ff;
      s_devsel_act = 1'b0;
      s_trdy_act   = 1'b0;
      s_stop_act   = 1'b0;
      s_own        = 1'b0;
      s_done       = (s_st_ff == pbc_pkg::S_DATA) && trdy_on && irdy_s;
      s_fin        = (s_st_ff == pbc_pkg::S_DATA) && !frame_s && irdy_s && (trdy_on || stop_on);
      case (s_st_ff)
         pbc_pkg::S_IDLE:
            if (s_hit)
            begin
               nxt_s_st     = pbc_pkg::S_DATA;
               s_devsel_act = 1'b1;
               s_own        = 1'b1;
            end
         pbc_pkg::S_DATA:
            if (s_fin)
               nxt_s_st = pbc_pkg::S_TURN;
            else
            begin
               s_own        = 1'b1;
               s_devsel_act = 1'b1;
               s_trdy_act   = !s_done && (trdy_on || slv_rdy);
               s_stop_act   = stop_on || slv_stop;
            end
         default:
            nxt_s_st = pbc_pkg::S_IDLE;
      endcase
   end

   // address, command and byte enable drive
   always_comb
   begin
      nxt_ad       = ad_o_ff;
      nxt_ad_oe_b  = 1'b1;
      nxt_cbe      = cbe_b_o_ff;
      nxt_cbe_oe_b = 1'b1;
      if (nxt_m_st == pbc_pkg::M_ADDR)
      begin
         nxt_ad       = mst_addr;
         nxt_ad_oe_b  = 1'b0;
         nxt_cbe      = mst_cmd;
         nxt_cbe_oe_b = 1'b0;
      end
      else if (nxt_m_st == pbc_pkg::M_DATA)
      begin
         nxt_cbe      = ~mst_be;
         nxt_cbe_oe_b = 1'b0;
         nxt_ad_oe_b  = !m_wr_ff;
         if (!(irdy_on && !m_done))
            nxt_ad = mst_wdata;
      end
      else if (s_st_ff == pbc_pkg::S_DATA && nxt_s_st == pbc_pkg::S_DATA && !s_wr_ff)
      begin
         nxt_ad_oe_b = 1'b0;
         if (!(trdy_on && !s_done))
            nxt_ad = slv_rdata;
      end
   end

   // sequencer state, all cleared by reset
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         m_st_ff    <= pbc_pkg::M_IDLE;
         s_st_ff    <= pbc_pkg::S_IDLE;
         frame_q_ff <= 1'b0;
         m_claim_ff <= 1'b0;
         m_wait_ff  <= 3'h0;
         m_cmd_ff   <= 4'h0;
         m_wr_ff    <= 1'b0;
         s_wr_ff    <= 1'b0;
      end
      else
      begin
         m_st_ff    <= nxt_m_st;
         s_st_ff    <= nxt_s_st;
         frame_q_ff <= frame_s;
         if (m_st_ff == pbc_pkg::M_IDLE)
         begin
            m_cmd_ff <= mst_cmd;
            m_wr_ff  <= mst_cmd[0];
         end
         if (m_st_ff == pbc_pkg::M_ADDR)
         begin
            m_claim_ff <= 1'b0;
            m_wait_ff  <= 3'h0;
         end
         else if (m_st_ff == pbc_pkg::M_DATA)
         begin
            m_claim_ff <= m_claim_ff || devsel_s;
            if (m_wait_ff != pbc_pkg::DEVSEL_WAIT)
               m_wait_ff <= m_wait_ff + 3'h1;
         end
         if (s_hit)
            s_wr_ff <= cbe_b_i[0];
      end
   end

   // bus data drive, floated under reset
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         ad_o_ff       <= pbc_pkg::RST_AD;
         ad_oe_b_ff    <= pbc_pkg::RST_OE_B;
         cbe_b_o_ff    <= pbc_pkg::RST_CBE;
         cbe_b_oe_b_ff <= pbc_pkg::RST_OE_B;
         par_o_ff      <= 1'b0;
         par_oe_b_ff   <= pbc_pkg::RST_OE_B;
      end
      else
      begin
         ad_o_ff       <= nxt_ad;
         ad_oe_b_ff    <= nxt_ad_oe_b;
         cbe_b_o_ff    <= nxt_cbe;
         cbe_b_oe_b_ff <= nxt_cbe_oe_b;
         par_o_ff      <= gen_par;
         par_oe_b_ff   <= ad_oe_b_ff;
      end
   end

   pbc_parity #(.W(36)) u_par_gen
   (
      .bits     ({ad_o_ff, cbe_b_o_ff}),
      .even_par (gen_par)
   );

   // parity check, address and data both one clock after capture
   assign rx_data = (m_done && !m_wr_ff && m_cmd_ff != pbc_pkg::CMD_SPECIAL)
                    || (s_done && s_wr_ff);
   assign chk_bad = chk_par != par_i;

   pbc_parity #(.W(36)) u_par_chk
   (
      .bits     (chk_ff),
      .even_par (chk_par)
   );

   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         chk_ff         <= 36'h0_0000_0000;
         aq_ff          <= 1'b0;
         dq_ff          <= 1'b0;
         serr_b_o_ff    <= 1'b0;
         serr_b_oe_b_ff <= pbc_pkg::RST_OE_B;
      end
      else
      begin
         if (frame_s && !frame_q_ff || rx_data)
            chk_ff <= {ad_i, cbe_b_i};
         aq_ff          <= s_addr_ph;
         dq_ff          <= rx_data;
         serr_b_o_ff    <= 1'b0;
         serr_b_oe_b_ff <= !(aq_ff && chk_bad);
      end
   end

   // sustained tri-state control lines
   pbc_sts_pin u_frame
   (
      .clk(clk), .rst_b(rst_b), .act(m_frame_act), .own(m_own),
      .pin_o(frame_b_o), .pin_oe_b(frame_b_oe_b)
   );
   pbc_sts_pin u_irdy
   (
      .clk(clk), .rst_b(rst_b), .act(m_irdy_act), .own(m_own),
      .pin_o(irdy_b_o), .pin_oe_b(irdy_b_oe_b)
   );
   pbc_sts_pin u_trdy
   (
      .clk(clk), .rst_b(rst_b), .act(s_trdy_act), .own(s_own),
      .pin_o(trdy_b_o), .pin_oe_b(trdy_b_oe_b)
   );
   pbc_sts_pin u_stop
   (
      .clk(clk), .rst_b(rst_b), .act(s_stop_act), .own(s_own),
      .pin_o(stop_b_o), .pin_oe_b(stop_b_oe_b)
   );
   pbc_sts_pin u_devsel
   (
      .clk(clk), .rst_b(rst_b), .act(s_devsel_act), .own(s_own),
      .pin_o(devsel_b_o), .pin_oe_b(devsel_b_oe_b)
   );
   pbc_sts_pin u_perr
   (
      .clk(clk), .rst_b(rst_b), .act(dq_ff && chk_bad), .own(1'b0),
      .pin_o(perr_b_o), .pin_oe_b(perr_b_oe_b)
   );

   // arbitration, interrupt and user-side results
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         inta_b_o_ff    <= 1'b0;
         inta_b_oe_b_ff <= pbc_pkg::RST_OE_B;
         req_b_o_ff     <= pbc_pkg::RST_PIN;
         req_b_oe_b_ff  <= pbc_pkg::RST_OE_B;
         mst_ack_ff     <= 1'b0;
         mst_end_ff     <= 1'b0;
         mst_stopped_ff <= 1'b0;
         mst_aborted_ff <= 1'b0;
         mst_rdata_ff   <= 32'h0000_0000;
         slv_sel_ff     <= 1'b0;
         slv_ack_ff     <= 1'b0;
         slv_end_ff     <= 1'b0;
         slv_cmd_ff     <= 4'h0;
         slv_addr_ff    <= 32'h0000_0000;
         slv_wdata_ff   <= 32'h0000_0000;
      end
      else
      begin
         inta_b_oe_b_ff <= !irq;
         req_b_o_ff     <= !(mst_req && m_st_ff == pbc_pkg::M_IDLE);
         req_b_oe_b_ff  <= 1'b0;
         mst_ack_ff     <= m_done;
         mst_end_ff     <= (m_st_ff == pbc_pkg::M_DATA) && (nxt_m_st == pbc_pkg::M_TURN);
         if (nxt_m_st == pbc_pkg::M_ADDR)
         begin
            mst_stopped_ff <= 1'b0;
            mst_aborted_ff <= 1'b0;
         end
         else
         begin
            mst_stopped_ff <= mst_stopped_ff || m_stop;
            mst_aborted_ff <= mst_aborted_ff || m_abort;
         end
         if (m_done)
            mst_rdata_ff <= ad_i;
         slv_sel_ff <= nxt_s_st == pbc_pkg::S_DATA;
         slv_ack_ff <= s_done;
         slv_end_ff <= s_fin;
         if (s_hit)
         begin
            slv_cmd_ff  <= cbe_b_i;
            slv_addr_ff <= ad_i;
         end
         if (s_done)
            slv_wdata_ff <= ad_i;
      end
   end

   assign ad_o        = ad_o_ff;
   assign ad_oe_b     = ad_oe_b_ff;
   assign cbe_b_o     = cbe_b_o_ff;
   assign cbe_b_oe_b  = cbe_b_oe_b_ff;
   assign par_o       = par_o_ff;
   assign par_oe_b    = par_oe_b_ff;
   assign serr_b_o    = serr_b_o_ff;
   assign serr_b_oe_b = serr_b_oe_b_ff;
   assign inta_b_o    = inta_b_o_ff;
   assign inta_b_oe_b = inta_b_oe_b_ff;
   assign req_b_o     = req_b_o_ff;
   assign req_b_oe_b  = req_b_oe_b_ff;
   assign mst_ack     = mst_ack_ff;
   assign mst_end     = mst_end_ff;
   assign mst_stopped = mst_stopped_ff;
   assign mst_aborted = mst_aborted_ff;
   assign mst_rdata   = mst_rdata_ff;
   assign slv_sel     = slv_sel_ff;
   assign slv_ack     = slv_ack_ff;
   assign slv_end     = slv_end_ff;
   assign slv_cmd     = slv_cmd_ff;
   assign slv_addr    = slv_addr_ff;
   assign slv_wdata   = slv_wdata_ff;

   // checks
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_b);

   sequence s_stop_last;
      m_st_ff == pbc_pkg::M_DATA && frame_b_o && !stop_b_i;
   endsequence
   sequence s_rx_bad;
      rx_data ##1 chk_bad;
   endsequence
   sequence s_apar_bad;
      aq_ff && chk_bad;
   endsequence

   a_frame_needs_gnt: assert property (
      $fell(frame_b_o) |-> (!$past(gnt_b_i) && $past(frame_b_i) && $past(irdy_b_i)))
      else $error("frame started without grant on idle bus");
   a_final_phase: assert property (
      ($rose(frame_b_o) && !frame_b_oe_b) |-> !irdy_b_o)
      else $error("frame released without initiator ready");
   a_irdy_held: assert property (
      (m_st_ff == pbc_pkg::M_DATA && !irdy_b_o && trdy_b_i && stop_b_i && !m_abort)
         |=> !irdy_b_o)
      else $error("initiator ready dropped before transfer");
   a_mst_xfer_ack: assert property (
      (m_st_ff == pbc_pkg::M_DATA && !irdy_b_o && !trdy_b_i) |=> mst_ack)
      else $error("completed data phase not reported");
   a_trdy_held: assert property (
      (s_st_ff == pbc_pkg::S_DATA && !trdy_b_o && irdy_b_i) |=> !trdy_b_o)
      else $error("target ready dropped before transfer");
   a_stop_ends: assert property (
      s_stop_last |=> m_st_ff == pbc_pkg::M_TURN ##1 m_st_ff == pbc_pkg::M_IDLE)
      else $error("master did not end on stop");
   a_cfg_needs_idsel: assert property (
      (s_addr_ph && !idsel_i && !s_mem) |=> devsel_b_o)
      else $error("unselected configuration access claimed");
   a_devsel_claim: assert property (
      (s_hit && s_st_ff == pbc_pkg::S_IDLE) |=> (!devsel_b_o && !devsel_b_oe_b))
      else $error("decoded access not claimed");
   a_serr_pulse: assert property (
      s_apar_bad |=> !serr_b_oe_b ##1 serr_b_oe_b)
      else $error("system error not a single clock");
   a_perr_timing: assert property (
      s_rx_bad |=> (!perr_b_o && !perr_b_oe_b))
      else $error("parity error not two clocks after data");
   a_no_special_perr: assert property (
      (m_st_ff == pbc_pkg::M_DATA && m_cmd_ff == pbc_pkg::CMD_SPECIAL) |=> !dq_ff)
      else $error("special cycle parity reported");
   a_inta_level: assert property (
      1'b1 |=> (inta_b_oe_b == !$past(irq) && !inta_b_o))
      else $error("interrupt line not following condition");
   a_req_idle: assert property (
      !req_b_o |-> ($past(mst_req) && $past(m_st_ff) == pbc_pkg::M_IDLE))
      else $error("request without pending master work");
endmodule // pbc_bus_ctl

//--- hw/pbc_pkg.sv
// shared constants and state types for the bus control block
package pbc_pkg;
   localparam logic [3:0] CMD_SPECIAL  = 4'h1;
   localparam logic [3:0] CMD_MEM_RD   = 4'h6;
   localparam logic [3:0] CMD_MEM_WR   = 4'h7;
   localparam logic [3:0] CMD_CFG_RD   = 4'hA;
   localparam logic [3:0] CMD_CFG_WR   = 4'hB;
   localparam int         AD_W         = 32;
   localparam int         CBE_W        = 4;
   localparam int         PERR_DLY     = 2;
   localparam int         SERR_CLKS    = 1;
   localparam logic [2:0] DEVSEL_WAIT  = 3'h5;
   localparam logic       RST_OE_B     = 1'b1;
   localparam logic       RST_PIN      = 1'b1;
   localparam logic [3:0] RST_CBE      = 4'hF;
   localparam logic [31:0] RST_AD      = 32'h0000_0000;

   typedef enum logic [1:0] {M_IDLE, M_ADDR, M_DATA, M_TURN} pbc_mst_st_t;
   typedef enum logic [1:0] {S_IDLE, S_DATA, S_TURN} pbc_slv_st_t;
endpackage

//--- hw/pbc_parity.sv
// even parity over a bit vector
module pbc_parity
#(
   parameter int W = 36
)
(
   input  wire logic [W-1:0] bits,
   output logic              even_par
);
   assign even_par = ^bits;
endmodule // pbc_parity

//--- hw/pbc_sts_pin.sv
// sustained tri-state pin driver, drives high one clock before release
module pbc_sts_pin
(
   input  wire logic clk,
   input  wire logic rst_b,
   input  wire logic act,
   input  wire logic own,
   output logic      pin_o,
   output logic      pin_oe_b
);
   logic pin_o_ff;
   logic pin_oe_b_ff;

   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         pin_o_ff    <= pbc_pkg::RST_PIN;
         pin_oe_b_ff <= pbc_pkg::RST_OE_B;
      end
      else
      begin
         pin_o_ff    <= !act;
         // a low line is driven high one clock before it floats
         pin_oe_b_ff <= !(act || own || (!pin_o_ff && !pin_oe_b_ff));
      end
   end

   assign pin_o    = pin_o_ff;
   assign pin_oe_b = pin_oe_b_ff;

   a_precharge_high: assert property (@(posedge clk) disable iff (!rst_b)
      (!pin_oe_b && !pin_o && !act && !own) |=> (!pin_oe_b && pin_o))
      else $error("line released without high drive");
   a_float_from_high: assert property (@(posedge clk) disable iff (!rst_b)
      $rose(pin_oe_b) |-> $past(pin_o))
      else $error("line floated from low");
endmodule // pbc_sts_pin

//--- bench/pbc_far.sv
// far-side model: arbiter and one target for the device's master cycles
module pbc_far
(
   input  wire logic clk,
   input  wire logic rst_b,
   input  wire logic req_b,
   input  wire logic frame_b,
   input  wire logic irdy_b,
   input  wire logic stop_en,
   output logic      gnt_b,
   output logic      devsel_b,
   output logic      trdy_b,
   output logic      stop_b
);
   timeunit 1ns;
   timeprecision 1ns;
   logic claim_ff;
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         gnt_b    <= 1'b1;
         claim_ff <= 1'b0;
         devsel_b <= 1'b1;
         trdy_b   <= 1'b1;
         stop_b   <= 1'b1;
      end
      else
      begin
         gnt_b <= req_b;
         if (!claim_ff && !frame_b)
         begin
            claim_ff <= 1'b1;
            devsel_b <= 1'b0;
            trdy_b   <= 1'b0;
            stop_b   <= !stop_en;
         end
         else if (claim_ff && frame_b && !irdy_b && (!trdy_b || !stop_b))
         begin
            claim_ff <= 1'b0;
            devsel_b <= 1'b1;
            trdy_b   <= 1'b1;
            stop_b   <= 1'b1;
         end
         else if (claim_ff && !irdy_b && !trdy_b && !stop_b)
            trdy_b <= 1'b1;
      end
   end
endmodule // pbc_far

//--- bench/pbc_bus_ctl_tb.sv
// testbench for the bus control block
module pbc_bus_ctl_tb;
   timeunit 1ns;
   timeprecision 1ns;
   int n_fail = 0;
   int check_count = 0;
   logic clk, rst_b, idsel_i, par_t, irq, mst_req, mst_rdy, mst_last, slv_rdy, slv_stop;
   logic frame_t, irdy_t, stop_en, gnt_b_i, p_devsel, p_trdy, p_stop;
   logic low_q = 1'b0;
   logic [31:0] ad_t, mst_addr, mst_wdata, slv_base, slv_mask, slv_rdata;
   logic [3:0]  cbe_t, mst_cmd, mst_be;
   logic frame_b_o, frame_b_oe_b, irdy_b_o, irdy_b_oe_b, trdy_b_o, trdy_b_oe_b;
   logic stop_b_o, stop_b_oe_b, devsel_b_o, devsel_b_oe_b, perr_b_o, perr_b_oe_b;
   logic serr_b_o, serr_b_oe_b, inta_b_o, inta_b_oe_b, req_b_o, req_b_oe_b, ad_oe_b;
   logic cbe_b_oe_b, par_o, par_oe_b, mst_ack, mst_end, mst_stopped, mst_aborted;
   logic slv_sel, slv_ack, slv_end;
   logic [31:0] ad_o, mst_rdata, slv_addr, slv_wdata;
   logic [3:0]  cbe_b_o, slv_cmd;
   // control lines are pulled up; each party pulls low when enabled
   wire logic        frame_b_i  = (frame_b_oe_b | frame_b_o) & frame_t;
   wire logic        irdy_b_i   = (irdy_b_oe_b | irdy_b_o) & irdy_t;
   wire logic        trdy_b_i   = (trdy_b_oe_b | trdy_b_o) & p_trdy;
   wire logic        stop_b_i   = (stop_b_oe_b | stop_b_o) & p_stop;
   wire logic        devsel_b_i = (devsel_b_oe_b | devsel_b_o) & p_devsel;
   wire logic [31:0] ad_i       = ad_oe_b ? ad_t : ad_o;
   wire logic [3:0]  cbe_b_i    = cbe_b_oe_b ? cbe_t : cbe_b_o;
   wire logic        par_i      = par_oe_b ? par_t : par_o;

   pbc_bus_ctl i_pbc_bus_ctl (.*);
   pbc_far i_pbc_far (.clk(clk), .rst_b(rst_b), .req_b(req_b_o | req_b_oe_b),
      .frame_b(frame_b_o | frame_b_oe_b), .irdy_b(irdy_b_o | irdy_b_oe_b),
      .stop_en(stop_en), .gnt_b(gnt_b_i), .devsel_b(p_devsel), .trdy_b(p_trdy),
      .stop_b(p_stop));

   always #10 clk = ~clk;

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp)
      begin
         n_fail++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic stop_test;
      $display("checks=%0d fails=%0d", check_count, n_fail);
      if (n_fail == 0 && check_count > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask

   // frame must be driven high for a clock before it floats
   always @(negedge clk)
   begin
      if (rst_b && low_q)
         chk(frame_b_oe_b, 0);
      low_q <= !frame_b_oe_b && !frame_b_o;
   end

   // device as master moving one word, optionally stopped by the target
   task automatic mst_wr(input logic stp, input logic [3:0] cmd);
      int n, k;
      stop_en = stp;
      mst_last = !stp;
      mst_cmd = cmd;
      mst_req = 1'b1;
      n = 0;
      while (!(frame_b_oe_b === 1'b0 && frame_b_o === 1'b0) && n < 20)
      begin
         @(negedge clk);
         n++;
      end
      chk(ad_o, mst_addr);
      chk(cbe_b_o, mst_cmd);
      mst_req = 1'b0;
      @(negedge clk);
      chk({par_oe_b, par_o}, {1'b0, ^{mst_addr, cmd}});
      n = 0;
      k = 0;
      while (mst_end !== 1'b1 && n < 20)
      begin
         @(negedge clk);
         k += mst_ack;
         n++;
      end
      chk(mst_end, 1);
      chk(mst_stopped, stp);
      chk(k, 1);
      chk(mst_aborted, 0);
      if (!cmd[0])
         chk(mst_rdata, ad_t);
   endtask

   // bench as master doing a configuration or memory write to the device
   task automatic slv_cfg(input logic sel, input logic bad_ap, input logic bad_dp,
                          input logic [3:0] cmd);
      int n_serr, n_perr, n_dev, n_ack;
      logic [31:0] d, a;
      logic hit;
      n_serr = 0;
      n_perr = 0;
      n_dev = 0;
      n_ack = 0;
      d = 32'hA5C3_0F96;
      a = (cmd == pbc_pkg::CMD_MEM_WR) ? 32'h1234_0040 : 32'h0000_0010;
      hit = sel || (cmd == pbc_pkg::CMD_MEM_WR);
      @(negedge clk);
      frame_t = 1'b0;
      idsel_i = sel;
      ad_t = a;
      cbe_t = cmd;
      @(negedge clk);
      par_t = ^{ad_t, cbe_t} ^ bad_ap;
      frame_t = 1'b1;
      irdy_t = 1'b0;
      ad_t = d;
      cbe_t = 4'h0;
      idsel_i = 1'b0;
      repeat (12)
      begin
         @(negedge clk);
         par_t = ^{d, 4'h0} ^ bad_dp;
         n_serr += !serr_b_oe_b;
         n_perr += !perr_b_oe_b && !perr_b_o;
         n_dev += !devsel_b_oe_b && !devsel_b_o;
         if (slv_ack === 1'b1)
         begin
            n_ack++;
            irdy_t = 1'b1;
            chk(slv_wdata, d);
            chk(slv_cmd, cmd);
            chk(slv_addr, a);
         end
      end
      irdy_t = 1'b1;
      chk(n_serr, bad_ap);
      chk(n_perr, hit & bad_dp);
      chk(n_dev > 0, hit);
      chk(n_ack, hit);
   endtask

   initial
   begin
      #100us;
      n_fail++;
      stop_test;
   end

   initial
   begin
      clk = 1'b0;
      rst_b = 1'b0;
      {idsel_i, par_t, irq, mst_req, mst_last, slv_stop, stop_en} = 7'h00;
      {frame_t, irdy_t, mst_rdy, slv_rdy} = 4'hF;
      ad_t = 32'h0000_0000;
      cbe_t = 4'h0;
      mst_addr = 32'h8000_0010;
      mst_wdata = 32'h1357_9BDF;
      mst_cmd = pbc_pkg::CMD_MEM_WR;
      mst_be = 4'hF;
      slv_base = 32'h1234_0000;
      slv_mask = 32'hFFFF_0000;
      slv_rdata = 32'h0000_0000;
      repeat (16) @(negedge clk);
      chk({frame_b_oe_b, irdy_b_oe_b, trdy_b_oe_b, stop_b_oe_b, devsel_b_oe_b,
           perr_b_oe_b, serr_b_oe_b, req_b_oe_b, ad_oe_b, par_oe_b}, 10'h3FF);
      rst_b = 1'b1;
      mst_wr(1'b0, pbc_pkg::CMD_MEM_WR);
      repeat (3) @(negedge clk);
      mst_wr(1'b1, pbc_pkg::CMD_MEM_WR);
      repeat (3) @(negedge clk);
      ad_t = 32'h2468_ACE0;
      par_t = ^ad_t;
      mst_wr(1'b0, pbc_pkg::CMD_MEM_RD);
      repeat (3) @(negedge clk);
      slv_cfg(1'b0, 1'b1, 1'b0, pbc_pkg::CMD_CFG_WR);
      repeat (3) @(negedge clk);
      slv_cfg(1'b1, 1'b0, 1'b1, pbc_pkg::CMD_CFG_WR);
      repeat (3) @(negedge clk);
      slv_cfg(1'b0, 1'b0, 1'b0, pbc_pkg::CMD_MEM_WR);
      irq = 1'b1;
      repeat (2) @(negedge clk);
      chk({inta_b_oe_b, inta_b_o}, 2'h0);
      irq = 1'b0;
      repeat (2) @(negedge clk);
      chk(inta_b_oe_b, 1);
      stop_test;
   end
endmodule // pbc_bus_ctl_tb
